/* logic/pcg_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pcg_top
    import pcg_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // system controls
    input  wire logic        system_osc_enable,
    input  wire logic        osc_in_stop_bit,
    input  wire logic        break_clear_enable,
    input  wire logic        debug_break,
    input  wire logic        stop_mode,
    // analog side clocks
    input  wire logic        pll_reference_clock,
    input  wire logic        vco_output_clock,
    // outputs
    output var  logic        osc_enable,
    output var  logic        vco_enable,
    output var  logic        crystal_clock_out,
    output var  logic        generator_output_clock,
    output var  logic        generator_interrupt,
    output var  logic        loop_filter_cap_pin_up,
    output var  logic        loop_filter_cap_pin_dn,
    output var  logic        filter_fast
);
    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] ref_sq, vco_sq, stp_sq;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sq <= 3'h0;
            vco_sq <= 3'h0;
            stp_sq <= 3'h0;
        end else begin
            ref_sq <= {ref_sq[1:0], pll_reference_clock};
            vco_sq <= {vco_sq[1:0], vco_output_clock};
            stp_sq <= {stp_sq[1:0], stop_mode};
        end
    end
    logic ref_lvl, vco_lvl, ref_rise, vco_rise, stopped;
    assign ref_lvl  = ref_sq[1];
    assign vco_lvl  = vco_sq[1];
    assign ref_rise = ref_sq[1] & ~ref_sq[2];   // rising reference clock edge
    assign vco_rise = vco_sq[1] & ~vco_sq[2];
    assign stopped  = stp_sq[1];

    // ------------------------------------------------------------
    // register state and axi slave
    // ------------------------------------------------------------
    pcg_ctrl_t          ctrl_q, ctrl_d;
    logic [MULT_W-1:0]  mult_q, mult_d;
    logic [LIN_W-1:0]   lin_q, lin_d;
    logic [1:0]         exp_q, exp_d;
    logic               flag_q, flag_d;
    logic               awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic               arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]        rdata_q, rdata_d, centre_hz;
    logic               lock_q, track_q, src_act_q, lock_chg;
    logic               wr_go, rd_go, can_clr;

    // centre-of-range frequency in hertz
    assign centre_hz = (NOM_CENTRE_HZ * {24'h0, lin_q}) << exp_q;
    assign wr_go     = awready_q & wready_q;
    assign rd_go     = arready_q;
    assign can_clr   = ~debug_break | break_clear_enable;

    always_comb begin
        ctrl_d    = ctrl_q;
        mult_d    = mult_q;
        lin_d     = lin_q;
        exp_d     = exp_q;
        flag_d    = flag_q;
        awready_d = awvalid & wvalid & ~awready_q & ~bvalid_q;
        wready_d  = awvalid & wvalid & ~wready_q & ~bvalid_q;
        bvalid_d  = bvalid_q & ~bready;
        bresp_d   = bresp_q;
        arready_d = arvalid & ~arready_q & ~rvalid_q;
        rvalid_d  = rvalid_q & ~rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = AXI_OKAY;
            case (awaddr)
                ADDR_CTRL: begin
                    if (wstrb[0]) begin
                        ctrl_d.pll_on     = wdata[CTRL_PLL_ON];
                        ctrl_d.src_pll    = wdata[CTRL_SRC_SEL];
                        ctrl_d.filt_track = wdata[CTRL_FILT];
                        ctrl_d.auto_mode  = wdata[CTRL_AUTO];
                        ctrl_d.irq_en     = wdata[CTRL_IRQ_EN];
                        if (wdata[CTRL_FLAG] && can_clr) begin
                            flag_d = 1'b0;
                        end
                    end
                end
                ADDR_MULT: begin
                    if (wstrb[0]) mult_d[7:0] = wdata[7:0];
                    if (wstrb[1]) mult_d[11:8] = wdata[11:8];
                end
                ADDR_RANGE: begin
                    if (wstrb[0]) lin_d = wdata[7:0];
                    if (wstrb[1]) exp_d = wdata[9:8];
                end
                ADDR_STATUS: ;
                default: bresp_d = AXI_SLVERR;
            endcase
        end
        // set wins over a clear in the same cycle
        if (lock_chg && ctrl_q.auto_mode) begin
            flag_d = 1'b1;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = AXI_OKAY;
            case (araddr)
                ADDR_CTRL:   rdata_d = {24'h0, flag_q, 2'h0, ctrl_q.irq_en, ctrl_q.auto_mode,
                                        ctrl_q.filt_track, ctrl_q.src_pll, ctrl_q.pll_on};
                ADDR_MULT:   rdata_d = {20'h0, mult_q};
                ADDR_RANGE:  rdata_d = {22'h0, exp_q, lin_q};
                // upper bits carry the centre frequency, which fits in 28 bits
                ADDR_STATUS: rdata_d = {centre_hz[27:0], flag_q, src_act_q, track_q,
                                        lock_q & ctrl_q.auto_mode};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = AXI_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= '0;
            mult_q    <= MULT_RST;
            lin_q     <= LIN_RST;
            exp_q     <= EXP_RST;
            flag_q    <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= AXI_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= AXI_OKAY;
            rdata_q   <= 32'h0;
        end else begin
            ctrl_q    <= ctrl_d;
            mult_q    <= mult_d;
            lin_q     <= lin_d;
            exp_q     <= exp_d;
            flag_q    <= flag_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // loop datapath: divider, phase detector, filter, lock detector
    // ------------------------------------------------------------
    logic              osc_run, pll_run, fb_rise;
    logic [MULT_W-1:0] div_q, div_d;
    pcg_pd_t           pd_q, pd_d;
    logic [1:0]        slow_q, slow_d, bus_q, bus_d;
    logic [MULT_W:0]   fbcnt_q, fbcnt_d;
    logic [3:0]        match_q, match_d;
    logic              lock_d, track_d, up_d, dn_d, fast_d, busclk_q, busclk_d;

    assign osc_run  = (system_osc_enable | osc_in_stop_bit) &
                      ~(stopped & ~osc_in_stop_bit);
    assign pll_run  = ctrl_q.pll_on & ~stopped & osc_run;
    assign fb_rise  = pll_run & vco_rise & (div_q == mult_q - 12'h1);
    assign lock_chg = lock_d ^ lock_q;

    always_comb begin
        div_d    = div_q;
        pd_d     = pd_q;
        slow_d   = slow_q + 2'h1;
        bus_d    = bus_q;
        busclk_d = busclk_q;
        fbcnt_d  = fbcnt_q;
        match_d  = match_q;
        // modulo divider counts oscillator edges up to N
        if (!pll_run) begin
            div_d = '0;
        end else if (vco_rise) begin
            div_d = fb_rise ? '0 : div_q + 12'h1;
        end
        // bus clock toggles every second oscillator edge: divide by four
        if (!pll_run) begin
            bus_d    = 2'h0;
            busclk_d = 1'b0;
        end else if (vco_rise) begin
            bus_d = bus_q + 2'h1;
            if (bus_q[0]) busclk_d = ~busclk_q;
        end
        // phase detector: earlier edge opens a pulse, later edge closes it
        case (pd_q)
            PD_IDLE: begin
                if (pll_run && ref_rise && !fb_rise) pd_d = PD_UP;
                else if (pll_run && fb_rise && !ref_rise) pd_d = PD_DN;
            end
            PD_UP:   if (fb_rise || !pll_run) pd_d = PD_IDLE;
            PD_DN:   if (ref_rise || !pll_run) pd_d = PD_IDLE;
            default: pd_d = PD_IDLE;
        endcase
        // lock detector: one feedback edge per reference period means match
        if (!pll_run) begin
            fbcnt_d = '0;
            match_d = 4'h0;
        end else if (ref_rise) begin
            fbcnt_d = {12'h0, fb_rise};
            if (fbcnt_q == 13'h1) begin
                if (match_q != LOCK_MATCH) match_d = match_q + 4'h1;
            end else begin
                match_d = 4'h0;
            end
        end else if (fb_rise) begin
            fbcnt_d = fbcnt_q + 13'h1;
        end
        lock_d  = (match_q == LOCK_MATCH);
        track_d = ctrl_q.auto_mode ? (match_q >= ACQ_MATCH) : ctrl_q.filt_track;
        fast_d  = pll_run & ~track_d;
        // tracking only passes one correction cycle in four
        up_d    = (pd_q == PD_UP) & (fast_d | (slow_q == TRACK_DIV));
        dn_d    = (pd_q == PD_DN) & (fast_d | (slow_q == TRACK_DIV));
    end

    // ------------------------------------------------------------
    // glitch-free source select and output registers
    // ------------------------------------------------------------
    logic xtal_q, gen_q, irq_q, up_q, dn_q, fast_q, oen_q, ven_q, sel_ok;
    assign sel_ok = ~ref_lvl & ~busclk_q;   // both sources low: safe to swap

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q     <= '0;
            pd_q      <= PD_IDLE;
            slow_q    <= 2'h0;
            bus_q     <= 2'h0;
            busclk_q  <= 1'b0;
            fbcnt_q   <= '0;
            match_q   <= 4'h0;
            lock_q    <= 1'b0;
            track_q   <= 1'b0;
            src_act_q <= 1'b0;
            xtal_q    <= 1'b0;
            gen_q     <= 1'b0;
            irq_q     <= 1'b0;
            up_q      <= 1'b0;
            dn_q      <= 1'b0;
            fast_q    <= 1'b0;
            oen_q     <= 1'b0;
            ven_q     <= 1'b0;
        end else begin
            div_q     <= div_d;
            pd_q      <= pd_d;
            slow_q    <= slow_d;
            bus_q     <= bus_d;
            busclk_q  <= busclk_d;
            fbcnt_q   <= fbcnt_d;
            match_q   <= match_d;
            lock_q    <= lock_d;
            track_q   <= track_d;
            if (sel_ok) src_act_q <= ctrl_q.src_pll & pll_run;
            xtal_q    <= osc_run & ref_lvl;
            gen_q     <= osc_run & (src_act_q ? busclk_q : ref_lvl);
            irq_q     <= osc_run & flag_q & ctrl_q.irq_en & ctrl_q.auto_mode;
            up_q      <= up_d;
            dn_q      <= dn_d;
            fast_q    <= fast_d;
            oen_q     <= osc_run;
            ven_q     <= pll_run;
        end
    end

    assign awready                = awready_q;
    assign wready                 = wready_q;
    assign bvalid                 = bvalid_q;
    assign bresp                  = bresp_q;
    assign arready                = arready_q;
    assign rvalid                 = rvalid_q;
    assign rresp                  = rresp_q;
    assign rdata                  = rdata_q;
    assign osc_enable             = oen_q;
    assign vco_enable             = ven_q;
    assign crystal_clock_out      = xtal_q;
    assign generator_output_clock = gen_q;
    assign generator_interrupt    = irq_q;
    assign loop_filter_cap_pin_up = up_q;
    assign loop_filter_cap_pin_dn = dn_q;
    assign filter_fast            = fast_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_manual_no_irq:  assert property (!ctrl_q.auto_mode |=> !generator_interrupt)
        else $error("interrupt raised in manual mode");
    chk_stop_low:       assert property (stopped && !osc_in_stop_bit |=>
        !crystal_clock_out && !generator_output_clock && !generator_interrupt)
        else $error("outputs not low in stop");
    chk_stop_pll_off:   assert property (stopped |=> !vco_enable)
        else $error("loop running in stop");
    chk_osc_keep:       assert property (osc_in_stop_bit |=> osc_enable)
        else $error("oscillator off with osc-in-stop set");
    chk_flag_protect:   assert property (debug_break && !break_clear_enable && !lock_chg
        && flag_q |=> flag_q)
        else $error("flag changed during protected break");
    chk_flag_set:       assert property (lock_chg && ctrl_q.auto_mode |=> flag_q)
        else $error("lock change did not set flag");
    chk_div_wrap:       assert property (fb_rise |=> div_q == 12'h0)
        else $error("divider did not wrap at N");
    chk_slow_track:     assert property (track_d && slow_q != TRACK_DIV |=> !loop_filter_cap_pin_up
        && !loop_filter_cap_pin_dn)
        else $error("tracking correction outside slow slot");
    chk_pd_close:       assert property (pd_q == PD_UP && fb_rise |=> pd_q == PD_IDLE)
        else $error("up pulse not closed by feedback edge");
    chk_bus_quarter:    assert property (vco_rise && pll_run && bus_q[0] |=>
        busclk_q != $past(busclk_q))
        else $error("bus clock not toggled");
endmodule : pcg_top
`default_nettype wire

/* shared/pcg_pkg.sv */
package pcg_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_MULT     = 4'h4;
    localparam logic [3:0]  ADDR_RANGE    = 4'h8;
    localparam logic [3:0]  ADDR_STATUS   = 4'hc;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          CTRL_PLL_ON   = 0;
    localparam int          CTRL_SRC_SEL  = 1;
    localparam int          CTRL_FILT     = 2;
    localparam int          CTRL_AUTO     = 3;
    localparam int          CTRL_IRQ_EN   = 4;
    localparam int          CTRL_FLAG     = 7;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int          STAT_LOCK     = 0;
    localparam int          STAT_TRACK    = 1;
    localparam int          STAT_SRC_ACT  = 2;
    localparam int          STAT_FLAG     = 3;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          MULT_W        = 12;
    localparam int          LIN_W         = 8;
    localparam logic [11:0] MULT_RST      = 12'h001;
    localparam logic [7:0]  LIN_RST       = 8'h01;
    localparam logic [1:0]  EXP_RST       = 2'h0;
    localparam logic [31:0] NOM_CENTRE_HZ = 32'h0001_16e8; // 71400 Hz
    // ------------------------------------------------------------
    // lock detector counts in reference periods
    // ------------------------------------------------------------
    localparam logic [3:0]  ACQ_MATCH     = 4'h4;
    localparam logic [3:0]  LOCK_MATCH    = 4'h8;
    localparam logic [1:0]  TRACK_DIV     = 2'h3;          // slow filter: 1 in 4 cycles
    localparam logic [1:0]  AXI_OKAY      = 2'h0;
    localparam logic [1:0]  AXI_SLVERR    = 2'h2;

    typedef struct packed {
        logic       irq_en;
        logic       auto_mode;
        logic       filt_track;
        logic       src_pll;
        logic       pll_on;
    } pcg_ctrl_t;

    typedef enum logic [2:0] {
        PD_IDLE = 3'b001,
        PD_UP   = 3'b010,
        PD_DN   = 3'b100
    } pcg_pd_t;
endpackage : pcg_pkg

/* dv/pcg_ref_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pcg_ref_model #(
    parameter int REF_HALF_NS = 600
) (
    // enables from the block
    input  wire logic        osc_run,
    input  wire logic        vco_run,
    input  wire logic [11:0] mult_n,
    // clocks toward the block
    output var  logic        ref_clk,
    output var  logic        vco_clk
);
    // crystal: stands low while the oscillator is off
    initial begin
        ref_clk = 1'b0;
        forever begin
            #(REF_HALF_NS);
            ref_clk = osc_run ? ~ref_clk : 1'b0;
        end
    end
    // oscillator runs at n times the reference, so feedback over n matches it
    initial begin
        vco_clk = 1'b0;
        forever begin
            #(REF_HALF_NS / ((mult_n == 12'h000) ? 1 : int'(mult_n)));
            vco_clk = vco_run ? ~vco_clk : 1'b0;
        end
    end
endmodule : pcg_ref_model
`default_nettype wire

/* dv/tb_pll_clock_generator_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pll_clock_generator_control
    import pcg_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, system_osc_enable, osc_in_stop_bit;
    logic        break_clear_enable, debug_break, stop_mode, pll_reference_clock;
    logic        vco_output_clock, osc_enable, vco_enable, crystal_clock_out;
    logic        generator_output_clock, generator_interrupt, pump_up, pump_dn, filter_fast;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [11:0] n_mult;
    int          err_total, compares, cnt;

    pcg_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .system_osc_enable, .osc_in_stop_bit, .break_clear_enable,
        .debug_break, .stop_mode, .pll_reference_clock, .vco_output_clock, .osc_enable,
        .vco_enable, .crystal_clock_out, .generator_output_clock, .generator_interrupt,
        .loop_filter_cap_pin_up(pump_up), .loop_filter_cap_pin_dn(pump_dn), .filter_fast);
    pcg_ref_model ref_src (.osc_run(osc_enable), .vco_run(vco_enable), .mult_n(n_mult),
        .ref_clk(pll_reference_clock), .vco_clk(vco_output_clock));

    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 64);
        if (n >= 64) err_total++;
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 64);
        if (n >= 64) err_total++;
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("bresp", r, AXI_OKAY);
    endtask : wr
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(what, d, exp);
        check("rresp", r, AXI_OKAY);
    endtask : rd_chk
    task automatic count_rise(input bit pick, input int span, output int c);
        logic prev, cur;
        c = 0;
        prev = 1'b0;
        repeat (span) begin
            @(posedge aclk);
            cur = pick ? generator_output_clock : crystal_clock_out;
            if (cur === 1'b1 && prev !== 1'b1) c++;
            prev = cur;
        end
    endtask : count_rise
    // expected status word: centre frequency 71.4 kHz times L times two to the E, then flags
    function automatic logic [31:0] stat(input logic [7:0] l, input logic [1:0] e,
                                         input logic [3:0] b);
        logic [31:0] c;
        c = (NOM_CENTRE_HZ * {24'h0, l}) << e;
        return {c[27:0], b};
    endfunction : stat
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_map;
        logic [31:0] d;
        logic [1:0]  r;
        check("vco off", vco_enable, 1'b0);
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("mult", ADDR_MULT, 32'h1);
        rd_chk("range", ADDR_RANGE, 32'h1);
        axi_wr(ADDR_STATUS, 32'hf, r);
        check("stat wr", r, AXI_OKAY);
        rd_chk("status", ADDR_STATUS, stat(8'h01, 2'h0, 4'h0));
        axi_rd(4'h2, d, r);
        check("bad rd", {d[29:0], r}, {30'h0, AXI_SLVERR});
    endtask : t_reset_map
    task automatic t_manual;
        n_mult = 12'h008;
        wr(ADDR_MULT, 32'h8);
        wr(ADDR_RANGE, 32'h5d);
        rd_chk("range", ADDR_RANGE, 32'h5d);
        wr(ADDR_CTRL, 32'h1);
        repeat (3) @(posedge aclk);
        check("pll on", {vco_enable, filter_fast}, 2'b11);
        repeat (400) @(posedge aclk);
        check("pump excl", pump_up & pump_dn, 1'b0);
        wr(ADDR_CTRL, 32'h5);
        repeat (3) @(posedge aclk);
        check("track", filter_fast, 1'b0);
        repeat (400) @(posedge aclk);
        wr(ADDR_CTRL, 32'h7);
        repeat (50) @(posedge aclk);
        rd_chk("man stat", ADDR_STATUS, stat(8'h5d, 2'h0, 4'h6));
        check("man irq", generator_interrupt, 1'b0);
    endtask : t_manual
    task automatic t_auto;
        wr(ADDR_CTRL, 32'h0);
        repeat (20) @(posedge aclk);
        wr(ADDR_CTRL, 32'h19);
        for (int i = 0; i < 3000 && generator_interrupt !== 1'b1; i++) @(posedge aclk);
        check("auto irq", generator_interrupt, 1'b1);
        check("auto slow", filter_fast, 1'b0);
        rd_chk("auto stat", ADDR_STATUS, stat(8'h5d, 2'h0, 4'hb));
        wr(ADDR_CTRL, 32'h1b);
        repeat (100) @(posedge aclk);
        count_rise(1'b1, 480, cnt);
        check("bus clk", (cnt >= 19 && cnt <= 21), 1'b1);
    endtask : t_auto
    task automatic t_break;
        {debug_break, break_clear_enable} <= 2'b10;
        wr(ADDR_CTRL, 32'h9b);
        rd_chk("kept", ADDR_STATUS, stat(8'h5d, 2'h0, 4'hf));
        break_clear_enable <= 1'b1;
        wr(ADDR_CTRL, 32'h9b);
        debug_break <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk("cleared", ADDR_STATUS, stat(8'h5d, 2'h0, 4'h7));
        check("irq off", generator_interrupt, 1'b0);
    endtask : t_break
    task automatic t_stop;
        stop_mode <= 1'b1;
        repeat (10) @(posedge aclk);
        check("stop", {osc_enable, vco_enable, crystal_clock_out, generator_output_clock,
            generator_interrupt}, 5'h0);
        osc_in_stop_bit <= 1'b1;
        repeat (10) @(posedge aclk);
        check("stop osc", {osc_enable, vco_enable}, 2'b10);
        count_rise(1'b0, 100, cnt);
        check("xtal runs", cnt > 0, 1'b1);
        {stop_mode, system_osc_enable} <= 2'b00;
        repeat (10) @(posedge aclk);
        check("osc by bit", osc_enable, 1'b1);
        osc_in_stop_bit <= 1'b0;
        repeat (10) @(posedge aclk);
        check("osc off", osc_enable, 1'b0);
    endtask : t_stop
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {system_osc_enable, osc_in_stop_bit, break_clear_enable, debug_break} = 4'h8;
        stop_mode = 1'b0;
        n_mult = 12'h001;
        {err_total, compares} = 64'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_map();
        t_manual();
        t_auto();
        t_break();
        t_stop();
        final_report();
    end
    // cut a hang short well past the expected run length
    initial begin
        #500000;
        err_total++;
        final_report();
    end
endmodule : tb_pll_clock_generator_control
`default_nettype wire
